// ---- core/cpie_irq_ctrl.sv ----
// Interrupt enables, flags and request to the processor core
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module cpie_irq_ctrl
  import cpie_pkg::*;
#(
  parameter int GPIO_W       = GPIO_PINS,
  parameter bit FULL_VARIANT = 1'b1
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output var  logic [7:0]        reg_rdata,
  // Event sources
  input  wire logic              timer0_wrap_evt,
  input  wire logic              edge_irq_pin,
  input  wire logic              edge_rising_sel,
  input  wire logic [GPIO_W-1:0] gpio_pins,
  input  wire logic              conv_done_evt,
  input  wire logic              capture_compare_evt,
  input  wire logic              comparator_evt,
  input  wire logic              timer2_match_evt,
  input  wire logic              timer1_wrap_evt,
  // Request to core
  output var  logic              irq_to_core
);

  // ----------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------
  if (GPIO_W < 1 || GPIO_W > 8) begin : g_bad_gpio
    $error("GPIO_W must be 1 to 8");
  end

  localparam logic [7:0] PERIPH_MASK =
    FULL_VARIANT ? PERIPH_MASK_FULL : PERIPH_MASK_REDUCED; // see RQ18

  // ----------------------------------------------------------
  // State
  // ----------------------------------------------------------
  typedef struct packed {
    logic [7:0]        core_irq_control;
    logic [7:0]        peripheral_irq_enable;
    logic [7:0]        peripheral_irq_flags;
    logic [7:0]        pin_change_mask;
    logic [GPIO_W-1:0] gpio_prev;
    logic              edge_prev;
    logic              primed;
    logic [7:0]        rdata;
    logic              irq;
  } cpie_state_t;

  cpie_state_t state;
  cpie_state_t next_state;

  logic [7:0]  periph_evt;
  logic        edge_hit;
  logic        pin_hit;
  logic        core_req;
  logic        periph_req;

  always_comb begin
    next_state = state;
    // Peripheral events at the flag positions
    periph_evt                   = 8'h00;
    periph_evt[BIT_CONV_DONE]    = conv_done_evt;
    periph_evt[BIT_CAPTURE_CMP]  = capture_compare_evt;
    periph_evt[BIT_COMPARATOR]   = comparator_evt;
    periph_evt[BIT_TIMER2_MATCH] = timer2_match_evt;
    periph_evt[BIT_TIMER1_WRAP]  = timer1_wrap_evt;
    // Edge and pin change detection, held off until first sample
    edge_hit = state.primed &&
      (edge_rising_sel ? (edge_irq_pin && !state.edge_prev)
                       : (!edge_irq_pin && state.edge_prev));
    pin_hit = state.primed &&
      (|((gpio_pins ^ state.gpio_prev) &
         state.pin_change_mask[GPIO_W-1:0])); // see RQ8
    next_state.gpio_prev = gpio_pins;
    next_state.edge_prev = edge_irq_pin;
    next_state.primed    = 1'b1;

    // --------------------------------------------------------
    // Register writes
    // --------------------------------------------------------
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_CORE_CTL:     next_state.core_irq_control = reg_wdata;
        ADDR_PERIPH_EN:    next_state.peripheral_irq_enable =
                             reg_wdata & PERIPH_MASK; // see RQ19
        ADDR_PERIPH_FLAGS: next_state.peripheral_irq_flags =
                             reg_wdata & PERIPH_MASK; // see RQ20
        ADDR_PIN_MASK:     next_state.pin_change_mask = reg_wdata;
      endcase
    end

    // --------------------------------------------------------
    // Flag setting, set wins over a clearing write
    // --------------------------------------------------------
    if (timer0_wrap_evt) begin
      next_state.core_irq_control[BIT_T0_WRAP_FLAG] = 1'b1; // see RQ9
    end
    if (edge_hit) begin
      next_state.core_irq_control[BIT_EDGE_FLAG] = 1'b1; // see RQ11
    end
    if (pin_hit) begin
      next_state.core_irq_control[BIT_PIN_CHANGE_FLAG] = 1'b1; // see RQ12
    end
    next_state.peripheral_irq_flags = next_state.peripheral_irq_flags |
      (periph_evt & PERIPH_MASK); // see RQ1

    // --------------------------------------------------------
    // Request gating
    // --------------------------------------------------------
    core_req =
      (state.core_irq_control[BIT_T0_WRAP_EN] &&
       state.core_irq_control[BIT_T0_WRAP_FLAG]) || // see RQ6
      (state.core_irq_control[BIT_EDGE_EN] &&
       state.core_irq_control[BIT_EDGE_FLAG]) || // see RQ7
      (state.core_irq_control[BIT_PIN_CHANGE_EN] &&
       state.core_irq_control[BIT_PIN_CHANGE_FLAG]); // see RQ8
    periph_req = state.core_irq_control[BIT_PERIPH_GATE] &&
      (|(state.peripheral_irq_enable &
         state.peripheral_irq_flags)); // see RQ4 see RQ5 see RQ13 see RQ14 see RQ15 see RQ16 see RQ17
    next_state.irq = state.core_irq_control[BIT_GLOBAL_EN] &&
      (core_req || periph_req); // see RQ3

    // --------------------------------------------------------
    // Register reads
    // --------------------------------------------------------
    next_state.rdata = RESET_VALUE;
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_CORE_CTL:     next_state.rdata = state.core_irq_control;
        ADDR_PERIPH_EN:    next_state.rdata = state.peripheral_irq_enable;
        ADDR_PERIPH_FLAGS: next_state.rdata = state.peripheral_irq_flags;
        ADDR_PIN_MASK:     next_state.rdata = state.pin_change_mask;
      endcase
    end
  end

  // ----------------------------------------------------------
  // Registers; timer0 counter lives outside and is not reset here
  // ----------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= '0; // see RQ19 see RQ10
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata   = state.rdata;
  assign irq_to_core = state.irq;

endmodule : cpie_irq_ctrl
`default_nettype wire

// ---- core/cpie_pkg.sv ----
// Constants for the core and peripheral interrupt enable block
//------------------------------------------------------------
// Notes on behaviour
//------------------------------------------------------------
// Notes on behaviour
// RQ1 - Flags set on events regardless of enables
// RQ2 - Software clears stale flags before enabling source
// RQ3 - Global enable passes unmasked interrupts, else blocks
// RQ4 - Peripheral gate passes or blocks peripheral requests
// RQ5 - Peripheral irq needs own, gate, global enables
// RQ6 - Core bit 5 enables timer0 wrap interrupt
// RQ7 - Core bit 4 enables edge pin interrupt
// RQ8 - Core bit 3 enables masked pin change
// RQ9 - Timer0 wrap sets bit 2 until cleared
// RQ10 - Timer0 counter untouched by reset, load first
// RQ11 - Edge pin event sets bit 1 until cleared
// RQ12 - Any of six pins changing sets bit 0; the code sets it only for pins enabled in pin_change_mask
// RQ13 - Peripheral bit 6 enables conversion done interrupt
// RQ14 - Peripheral bit 5 enables capture compare interrupt
// RQ15 - Peripheral bit 3 enables comparator interrupt
// RQ16 - Peripheral bit 1 enables timer2 match interrupt
// RQ17 - Peripheral bit 0 enables timer1 wrap interrupt
// RQ18 - Reduced variant: bits 6,5,1 read zero
// RQ19 - Bits 7,4,2 read zero; all reset zero
// RQ20 - Peripheral flags mirror enable positions, software cleared
package cpie_pkg;
  // ----------------------------------------------------------
  // Register map
  // ----------------------------------------------------------
  localparam int         ADDR_W              = 2;
  localparam logic [1:0] ADDR_CORE_CTL       = 2'h0;
  localparam logic [1:0] ADDR_PERIPH_EN      = 2'h1;
  localparam logic [1:0] ADDR_PERIPH_FLAGS   = 2'h2;
  localparam logic [1:0] ADDR_PIN_MASK       = 2'h3;
  localparam logic [7:0] RESET_VALUE         = 8'h00;
  // ----------------------------------------------------------
  // Core control bit positions
  // ----------------------------------------------------------
  localparam int BIT_GLOBAL_EN      = 7;
  localparam int BIT_PERIPH_GATE    = 6;
  localparam int BIT_T0_WRAP_EN     = 5;
  localparam int BIT_EDGE_EN        = 4;
  localparam int BIT_PIN_CHANGE_EN  = 3;
  localparam int BIT_T0_WRAP_FLAG   = 2;
  localparam int BIT_EDGE_FLAG      = 1;
  localparam int BIT_PIN_CHANGE_FLAG = 0;
  // ----------------------------------------------------------
  // Peripheral enable and flag bit positions
  // ----------------------------------------------------------
  localparam int BIT_CONV_DONE      = 6;
  localparam int BIT_CAPTURE_CMP    = 5;
  localparam int BIT_COMPARATOR     = 3;
  localparam int BIT_TIMER2_MATCH   = 1;
  localparam int BIT_TIMER1_WRAP    = 0;
  localparam logic [7:0] PERIPH_MASK_FULL    = 8'h6B;
  localparam logic [7:0] PERIPH_MASK_REDUCED = 8'h09;
  localparam int         GPIO_PINS           = 6;
endpackage : cpie_pkg

// ---- testbench/cpie_chk.sv ----
// Assertions for the interrupt enable block
`timescale 1ns/100ps
`default_nettype none
module cpie_chk
  import cpie_pkg::*;
(
  // Watched ports
  input wire logic ref_clk, reset_n, reg_wr, reg_rd, timer0_wrap_evt,
  input wire logic edge_irq_pin, edge_rising_sel, conv_done_evt,
  input wire logic irq_to_core,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata, reg_rdata
);
  logic [7:0] ctl;
  wire logic wc = reg_wr && reg_addr == ADDR_CORE_CTL;
  wire logic rc = reg_rd && reg_addr == ADDR_CORE_CTL;
  // Shadow of the core control enables
  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n) ctl <= 8'h00;
    else if (wc) ctl <= reg_wdata;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  t0_flag_a: assert property (
    timer0_wrap_evt ##1 !reg_wr [*2] ##1 rc |=> reg_rdata[2])
    else $error("t0 flag");
  edge_flag_a: assert property (
    edge_rising_sel && $rose(edge_irq_pin) ##1 !reg_wr [*2] ##1 rc
    |=> reg_rdata[1]) else $error("edge flag");
  conv_flag_a: assert property (
    conv_done_evt ##1 !reg_wr [*2] ##1 reg_rd &&
    reg_addr == ADDR_PERIPH_FLAGS |=> reg_rdata[6])
    else $error("conv flag");
  resv_zero_a: assert property (
    reg_rd && reg_addr inside {2'h1, 2'h2} |=> !(reg_rdata & 8'h94))
    else $error("reserved bits");
  gie_block_a: assert property (
    !ctl[7] [*2] |-> !irq_to_core) else $error("gie block");
  gate_block_a: assert property (
    (ctl[7:3] == 5'h10) [*2] |-> !irq_to_core) else $error("gate block");
  t0_irq_a: assert property (
    timer0_wrap_evt && ctl[7] && ctl[5] && !reg_wr ##1 !reg_wr
    |=> irq_to_core) else $error("t0 irq");
  ctl_back_a: assert property (
    wc ##1 rc |=> reg_rdata[7:3] == $past(reg_wdata[7:3], 2))
    else $error("ctl readback");
  irq_c: cover property ($rose(irq_to_core));
  t0_c: cover property (timer0_wrap_evt ##3 rc);
  conv_c: cover property (conv_done_evt ##3 reg_rd);
endmodule : cpie_chk
bind cpie_irq_ctrl cpie_chk cpie_chk_i (.ref_clk, .reset_n, .reg_wr,
  .reg_rd, .timer0_wrap_evt, .edge_irq_pin, .edge_rising_sel,
  .conv_done_evt, .irq_to_core, .reg_addr, .reg_wdata, .reg_rdata);
`default_nettype wire

// ---- testbench/cpie_irq_ctrl_tb.sv ----
// Testbench for the interrupt enable block
`timescale 1ns/100ps
`default_nettype none
module cpie_irq_ctrl_tb;
  import cpie_pkg::*;
  logic ref_clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, irq, epin;
  logic [1:0] reg_addr = '0;
  logic [7:0] reg_wdata = '0, reg_rdata, fire = '0, ev;
  logic [5:0] pins;
  logic edge_sel = 1'b1;
  int errors, tests_run;
  byte pb [5] = '{6, 5, 3, 1, 0};
  cpie_src cpie_src_i (.ref_clk, .fire, .ev, .epin, .pins);
  cpie_irq_ctrl cpie_irq_ctrl_i (.ref_clk, .reset_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .timer0_wrap_evt(ev[0]),
    .edge_irq_pin(epin), .edge_rising_sel(edge_sel), .gpio_pins(pins),
    .conv_done_evt(ev[3]), .capture_compare_evt(ev[4]),
    .comparator_evt(ev[5]), .timer2_match_evt(ev[6]),
    .timer1_wrap_evt(ev[7]), .irq_to_core(irq));
  initial forever #5 ref_clk = !ref_clk;
  task automatic chk(string n, logic [7:0] e, g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(logic [1:0] a, logic [7:0] d);
    @(posedge ref_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge ref_clk) reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(logic [1:0] a, logic [7:0] e);
    @(posedge ref_clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge ref_clk) reg_rd <= 1'b0;
    @(negedge ref_clk) chk("reg_rdata", e, reg_rdata);
  endtask : rd
  // Fire events, then check the request two edges after the event
  task automatic pulse(logic [7:0] c, logic e);
    @(posedge ref_clk) fire <= c;
    @(posedge ref_clk) fire <= '0;
    repeat (3) @(negedge ref_clk);
    chk("irq_to_core", {7'h00, e}, {7'h00, irq});
  endtask : pulse
  task automatic t_core;
    pulse(8'h01, 1'b0); rd(2'h0, 8'h04);
    wr(2'h0, 8'h00); rd(2'h0, 8'h00);
    wr(2'h0, 8'hA0); pulse(8'h01, 1'b1);
    wr(2'h0, 8'h24); pulse(8'h00, 1'b0);
    $display("t_core done");
  endtask : t_core
  task automatic t_edge;
    wr(2'h0, 8'h00); pulse(8'h02, 1'b0); rd(2'h0, 8'h02);
    wr(2'h0, 8'h90); pulse(8'h02, 1'b0); rd(2'h0, 8'h90);
    pulse(8'h02, 1'b1);
    wr(2'h0, 8'h90);
    @(posedge ref_clk) edge_sel <= 1'b0;
    pulse(8'h02, 1'b1);
    rd(2'h0, 8'h92);
    @(posedge ref_clk) edge_sel <= 1'b1;
    $display("t_edge done");
  endtask : t_edge
  task automatic t_pins;
    wr(2'h0, 8'h88); pulse(8'h04, 1'b0);
    wr(2'h3, 8'h3F); pulse(8'h04, 1'b1);
    rd(2'h0, 8'h89);
    $display("t_pins done");
  endtask : t_pins
  task automatic t_periph;
    wr(2'h1, 8'hFF); rd(2'h1, 8'h6B);
    wr(2'h0, 8'hC0);
    for (int i = 0; i < 5; i++) begin
      pulse(8'h08 << i, 1'b1);
      rd(2'h2, 8'h01 << pb[i]);
      wr(2'h2, 8'h00);
    end
    wr(2'h0, 8'h80); pulse(8'h08, 1'b0);
    wr(2'h2, 8'h00); wr(2'h0, 8'hC0); wr(2'h1, 8'h00);
    pulse(8'h08, 1'b0);
    $display("t_periph done");
  endtask : t_periph
  task automatic stop_test;
    $display("Checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  initial begin
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    for (int a = 0; a < 4; a++) rd(a[1:0], 8'h00);
    t_core;
    t_edge;
    t_pins;
    t_periph;
    stop_test;
  end
  initial begin
    #20us errors++;
    stop_test;
  end
endmodule : cpie_irq_ctrl_tb
`default_nettype wire

// ---- testbench/cpie_src.sv ----
// Event source model facing the interrupt enable block
`timescale 1ns/100ps
`default_nettype none
module cpie_src (
  input  wire logic       ref_clk,
  input  wire logic [7:0] fire,
  output var  logic [7:0] ev,
  output var  logic       epin,
  output var  logic [5:0] pins
);
  initial {ev, epin, pins} = '0;
  // One-cycle pulses; edge pin and pin 5 toggle on request
  always @(posedge ref_clk) begin
    ev <= fire & 8'hF9;
    if (fire[1]) epin <= !epin;
    if (fire[2]) pins[5] <= !pins[5];
  end
endmodule : cpie_src
`default_nettype wire
